// ---- bench/relay_output_byte_port_tb.sv ----
// Purpose: self-checking bench for the relay output byte port
// Assumes: shortened relay and blink counts
// Notes: each read notes its expected byte in a queue for the monitor
`timescale 1ns/1ps
module relay_output_byte_port_tb;
    localparam int ON = 10, OFF = 5, HB = 8;
    logic       i_clock = 0, i_rst_n = 0, rdp = 0, wr, rd, o_stat_green, o_stat_red, g, r;
    logic [7:0] a, d, o_rdata, o_relay, o_chan_led, x = 8'h59, q[$];
    logic [4:0] err = 5'h0;
    int         mismatches = 0, samples_checked = 0, n, t;
    initial forever #50 i_clock = ~i_clock;
    rob_cpu rob_cpu_inst (.i_clock(i_clock), .o_addr(a), .o_wdata(d), .o_wr(wr), .o_rd(rd));
    rob_port #(.ON_CYCLES_P(ON), .OFF_CYCLES_P(OFF), .HALF_BLINK_P(HB)) rob_port_inst (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_addr(a), .i_wdata(d), .i_wr(wr), .i_rd(rd), .i_bus_fail(err[0]),
        .i_overload(err[1]), .i_short(err[2]), .i_overheat(err[3]), .i_cfg_err(err[4]), .o_rdata(o_rdata),
        .o_relay(o_relay), .o_chan_led(o_chan_led), .o_stat_green(o_stat_green), .o_stat_red(o_stat_red));
    function automatic logic [7:0] xs(input logic [7:0] v);
        v = v ^ (v << 3);
        v = v ^ (v >> 5);
        return v ^ (v << 1);
    endfunction : xs
    task automatic cmp(input logic [7:0] gv, input logic [7:0] ev);
        samples_checked++;
        if (gv !== ev)
        begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, gv, ev);
        end
    endtask : cmp
    task automatic rd8(input logic [7:0] ad, input logic [7:0] ev);
        q.push_back(ev);
        rob_cpu_inst.acc(1'b0, ad, 8'h00);
    endtask : rd8
    task automatic finish_test;
        if (q.size() != 0) mismatches++;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    // read data are taken one cycle after the strobe, pre-update at the edge
    always @(posedge i_clock)
    begin
        if (rdp) cmp(o_rdata, q.pop_front());
        rdp <= rd;
    end
    initial
    begin
        repeat (5) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd8(8'h04, 8'h00);
        for (n = 0; n < 6; n++)
        begin
            x = xs(x);
            err <= x[4:0];
            rob_cpu_inst.acc(1'b1, 8'h00, x);
            rob_cpu_inst.acc(1'b1, 8'h01, ~x); // write elsewhere is ignored
            repeat (ON + OFF + 4) @(posedge i_clock);
            cmp(o_relay, x);
            cmp(o_chan_led, x);
            if (x[3:1] != 3'h0) cmp({7'h00, o_stat_red}, 8'h01);
            if (!x[0]) cmp({7'h00, o_stat_green}, 8'h01);
            rd8(8'h04, x);
            rd8(8'h00, 8'h00);
        end
        err <= 5'h11;
        repeat (4) @(posedge i_clock);
        t = 0;
        repeat (64)
        begin
            {g, r} = {o_stat_green, o_stat_red};
            @(posedge i_clock);
            t += (o_stat_green !== g) + (o_stat_red !== r);
        end
        cmp(8'(t), 8'h10);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd8(8'h04, 8'h00);
        repeat (2) @(posedge i_clock);
        finish_test();
    end
    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (3000) @(posedge i_clock);
        mismatches++;
        finish_test();
    end
endmodule : relay_output_byte_port_tb

// ---- bench/rob_cpu.sv ----
// Purpose: controller model that drives the register port
// Assumes: one-cycle strobes, slave never waits
// Notes: a gap of one cycle between accesses, simpler than back to back
`timescale 1ns/1ps
module rob_cpu (
    input  wire logic  i_clock,
    output logic [7:0] o_addr, o_wdata,
    output logic       o_wr, o_rd
);
    initial {o_addr, o_wdata, o_wr, o_rd} = 18'h0;
    // one strobe for one cycle, changed right after the edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        {o_wr, o_rd, o_addr, o_wdata} <= {w, !w, a, d};
        @(posedge i_clock);
        {o_wr, o_rd} <= 2'h0;
    endtask : acc
endmodule : rob_cpu

// ---- bench/rob_port_chk.sv ----
// Purpose: assertions on the relay output byte port
// Assumes: one clock domain, async active-low reset
// Notes: relay timing watched on channel 0 only, bounded by the scaled limits
`timescale 1ns/1ps
module rob_port_chk #(parameter int ON = 10, parameter int OFF = 5) (
    input wire logic       i_clock, i_rst_n, i_wr, i_rd, i_bus_fail, i_overload, i_short, i_overheat,
    input wire logic       i_cfg_err, o_stat_green, o_stat_red,
    input wire logic [7:0] i_addr, i_wdata, o_rdata, o_relay, o_chan_led
);
    localparam int ONB  = 2 * ON;  // delays sit at half the limit
    localparam int OFFB = 2 * OFF;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire hw = i_overload | i_short | i_overheat;
    // cycles for which channel 0 led and relay have disagreed
    logic [31:0] lag_ff;
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            lag_ff <= 32'h0;
        else if (o_chan_led[0] != o_relay[0])
            lag_ff <= lag_ff + 32'h1;
        else
            lag_ff <= 32'h0;
    end
    // a write at offset zero, then the image reaches the leds
    sequence s_wr0;
        i_wr && i_addr == 8'h00;
    endsequence
    a_image_to_led: assert property (s_wr0 |=> ##1 o_chan_led == $past(i_wdata, 2))
        else $error("led byte wrong");
    a_read_zero: assert property (!(i_rd && i_addr == 8'h04) |=> o_rdata == 8'h00)
        else $error("rdata not zero");
    a_green_ok: assert property (!i_bus_fail |=> o_stat_green) else $error("green off");
    a_red_fault: assert property (hw |=> o_stat_red) else $error("red off");
    a_red_quiet: assert property (!hw && !i_cfg_err |=> !o_stat_red) else $error("red on");
    a_relay_on: assert property (o_chan_led[0] && !o_relay[0] |-> lag_ff <= ONB)
        else $error("relay late on");
    a_relay_off: assert property (!o_chan_led[0] && o_relay[0] |-> lag_ff <= OFFB)
        else $error("relay late off");
    a_relay_cause: assert property ($rose(o_relay[0]) |-> o_chan_led[0]) else $error("relay rose");
endmodule : rob_port_chk
bind rob_port rob_port_chk #(.ON(ON_CYCLES_P), .OFF(OFF_CYCLES_P)) rob_port_chk_inst (.*);

// ---- core/rob_pkg.sv ----
// Purpose: constants for the eight-channel relay output byte port
// Assumes: 10 MHz system clock, register port with one-cycle read latency
// Notes: relay delays are emulated as fixed delay counts inside the limits
package rob_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam logic [7:0]  OUT_IMAGE_OFS   = 8'h00;
    localparam logic [7:0]  STATUS_OFS      = 8'h04;
    localparam logic [7:0]  OUT_IMAGE_RST   = 8'h00;
    localparam int          ON_DELAY_MS     = 10;
    localparam int          OFF_DELAY_MS    = 5;
    // on delay kept at half the limit, off at half the limit
    localparam int          ON_CYCLES       = (CLK_HZ / 1000) * ON_DELAY_MS / 2;
    localparam int          OFF_CYCLES      = (CLK_HZ / 1000) * OFF_DELAY_MS / 2;
    localparam int          BLINK_HZ        = 1;
    localparam int          HALF_BLINK_CYC  = CLK_HZ / (2 * BLINK_HZ);
    localparam int          CNT_W           = 24;
    localparam logic [31:0] MODULE_ID       = 32'h0000_0001; // arbitrary value
endpackage : rob_pkg

// ---- core/rob_port.sv ----
// Purpose: relay output byte port with channel and status bar indicators
// Assumes: error and bus health inputs are synchronous levels
// Notes: reads at the status offset show relay state; the output byte reads zero
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module rob_port #(
    parameter int ON_CYCLES_P   = rob_pkg::ON_CYCLES,
    parameter int OFF_CYCLES_P  = rob_pkg::OFF_CYCLES,
    parameter int HALF_BLINK_P  = rob_pkg::HALF_BLINK_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_bus_fail,
    input  wire logic       i_overload,
    input  wire logic       i_short,
    input  wire logic       i_overheat,
    input  wire logic       i_cfg_err,
    output logic      [7:0] o_rdata,
    output logic      [7:0] o_relay,
    output logic      [7:0] o_chan_led,
    output logic            o_stat_green,
    output logic            o_stat_red
);
    // commanded output image, one bit per relay channel
    logic [7:0]                image_ff;

    // relay drive as the channels really switch, after their delay
    logic [7:0]                relay_ff;

    // registered copies that leave the block
    logic [7:0]                chled_ff;
    logic [7:0]                rdata_ff;
    logic                      green_ff;
    logic                      red_ff;

    // shared blink timebase, one half period per phase
    logic                      phase_ff;
    logic [rob_pkg::CNT_W-1:0] blink_ff;

    // per-channel delay counters, one word for each relay
    logic [rob_pkg::CNT_W-1:0] dly_ff [8];

    // delay limit for a channel heading to the given state;
    // the count stops one short because the relay register adds the last cycle
    function automatic logic [rob_pkg::CNT_W-1:0] rob_delay_limit(input logic target);
        logic [rob_pkg::CNT_W-1:0] lim;
        if (target)
            lim = rob_pkg::CNT_W'(ON_CYCLES_P - 1);
        else
            lim = rob_pkg::CNT_W'(OFF_CYCLES_P - 1);
        return lim;
    endfunction : rob_delay_limit

    // one status indicator: steady when its condition holds, else blinking or dark;
    // steady wins so a real fault is never hidden behind a blink
    function automatic logic rob_indicator(input logic steady,
                                           input logic blink,
                                           input logic phase);
        logic lit;
        if (steady)
            lit = 1'b1;
        else if (blink)
            lit = phase;
        else
            lit = 1'b0;
        return lit;
    endfunction : rob_indicator

    // register decode; the output byte itself is write only
    wire         wr_image  = i_wr && (i_addr == rob_pkg::OUT_IMAGE_OFS);
    wire         rd_stat   = i_rd && (i_addr == rob_pkg::STATUS_OFS);

    // every other read, the output byte included, answers zero
    wire [7:0]   nxt_rdata = rd_stat ? relay_ff : 8'h00;

    // hardware faults share one steady red; the cause is not told apart
    wire         hw_err    = i_overload || i_short || i_overheat;

    // blink timebase next state; wraps at the half period
    wire         blink_end = (blink_ff == rob_pkg::CNT_W'(HALF_BLINK_P - 1));
    wire [rob_pkg::CNT_W-1:0] nxt_blink = blink_end ? '0 : rob_pkg::CNT_W'(blink_ff + 1'b1);
    wire         nxt_phase = blink_end ? ~phase_ff : phase_ff;

    // red: steady error wins over blinking configuration error
    wire         nxt_red   = rob_indicator(hw_err, i_cfg_err, phase_ff);

    // green: steady while the bus is healthy, blinking once it fails
    wire         nxt_green = rob_indicator(!i_bus_fail, i_bus_fail, phase_ff);

    // output byte holds until rewritten
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            image_ff <= rob_pkg::OUT_IMAGE_RST;
        else if (wr_image)
            image_ff <= i_wdata;
    end

    // shared 1 Hz blink phase so green and red blink in step
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            blink_ff <= '0;
            phase_ff <= 1'b0;
        end
        else
        begin
            blink_ff <= nxt_blink;
            phase_ff <= nxt_phase;
        end
    end

    // per-channel relay delay; a reversal mid-delay restarts the count,
    // so a short glitch on the image never reaches the contact
    for (genvar n = 0; n < 8; n++)
    begin : g_ch
        // the channel is still travelling while image and relay differ
        wire                      differ    = image_ff[n] ^ relay_ff[n];
        wire [rob_pkg::CNT_W-1:0] lim       = rob_delay_limit(image_ff[n]);
        wire                      done      = differ && (dly_ff[n] >= lim);

        // counter clears when idle or done, otherwise counts up
        wire [rob_pkg::CNT_W-1:0] nxt_dly   = (!differ || done) ? '0
                                                                : rob_pkg::CNT_W'(dly_ff[n] + 1'b1);

        // relay takes the commanded state only when its delay has run out
        wire                      nxt_relay = done ? image_ff[n] : relay_ff[n];

        always_ff @(posedge i_clock or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                dly_ff[n]   <= '0;
                relay_ff[n] <= 1'b0;
            end
            else
            begin
                dly_ff[n]   <= nxt_dly;
                relay_ff[n] <= nxt_relay;
            end
        end
    end

    // channel leds follow the command, not the delayed contact,
    // so the user sees the request at once
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            chled_ff <= 8'h00;
        else
            chled_ff <= image_ff;
    end

    // read data stand one cycle, then fall back to zero
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    // status bar green
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            green_ff <= 1'b0;
        else
            green_ff <= nxt_green;
    end

    // status bar red
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            red_ff <= 1'b0;
        else
            red_ff <= nxt_red;
    end

    // every output comes straight from its register;
    // nothing combinational reaches the pins
    assign o_relay      = relay_ff;
    assign o_chan_led   = chled_ff;
    assign o_rdata      = rdata_ff;
    assign o_stat_green = green_ff;
    assign o_stat_red   = red_ff;
endmodule : rob_port
